// ---- dcsw_pkg.sv ----
// Package with register map, field positions, reset values and timing constants
package dcsw_pkg;
  localparam logic [11:0] DCSW_ADDR_STATUS   = 12'h000;
  localparam logic [11:0] DCSW_ADDR_COMMAND  = 12'h004;
  localparam logic [11:0] DCSW_ADDR_SPEEDREF = 12'h008;
  localparam logic [11:0] DCSW_ADDR_OUTFREQ  = 12'h00C;
  localparam logic [11:0] DCSW_ADDR_CONFIG   = 12'h010;
  localparam logic [11:0] DCSW_ADDR_LOLIM    = 12'h014;
  localparam logic [11:0] DCSW_ADDR_HILIM    = 12'h018;
  localparam logic [11:0] DCSW_ADDR_TMO      = 12'h01C;
  localparam logic [11:0] DCSW_ADDR_DRVOUT   = 12'h020;

  // Command word fields
  localparam int CMD_PRESET_LO = 0;
  localparam int CMD_PRESET_HI = 1;
  localparam int CMD_DC_BRAKE  = 2;
  localparam int CMD_COAST     = 3;
  localparam int CMD_QSTOP     = 4;
  localparam int CMD_FREEZE    = 5;
  localparam int CMD_START     = 6;
  localparam int CMD_RESET     = 7;
  localparam int CMD_VALID     = 10;
  localparam int CMD_RELAY1    = 11;
  localparam int CMD_RELAY2    = 12;

  // Status word fields
  localparam int ST_CTRL_READY  = 0;
  localparam int ST_DRIVE_READY = 1;
  localparam int ST_STANDBY     = 2;
  localparam int ST_TRIP        = 3;
  localparam int ST_TRIP_LOCK   = 6;
  localparam int ST_WARNING     = 7;
  localparam int ST_ON_REF      = 8;
  localparam int ST_SERIAL_OK   = 9;
  localparam int ST_IN_RANGE    = 10;
  localparam int ST_RUNNING     = 11;
  localparam int ST_VOLT_WARN   = 13;
  localparam int ST_CURR_WARN   = 14;
  localparam int ST_THERM_WARN  = 15;

  // Config register fields
  localparam int CFG_RELAY1_EN = 0;
  localparam int CFG_RELAY2_EN = 1;

  // Reset values
  localparam logic [15:0] CMD_RST      = 16'h0000;
  localparam logic [15:0] SPEEDREF_RST = 16'h0000;
  localparam logic [1:0]  CONFIG_RST   = 2'h0;
  localparam logic [15:0] LOLIM_RST    = 16'h0000;
  localparam logic [15:0] HILIM_RST    = 16'h4000;
  localparam logic [31:0] TMO_RST      = 32'h0000_0000;

  // Full scale of speed reference and output frequency (100 percent)
  localparam logic [15:0] FULL_SCALE = 16'h4000;

  // Bus timeout unit: 1 ms at 25 MHz
  localparam int CLK_HZ     = 25000000;
  localparam int TMO_UNIT_US = 1000;
  localparam int TMO_UNIT_CYC = (CLK_HZ / 1000000) * TMO_UNIT_US;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- dcsw_top.sv ----
// Drive control and status word register bank on AHB-Lite
// Operation
// - Status bit 00 high when ready for operation, low otherwise.
// - Status bit 01 set when ready but a coast command is active.
// - Status bit 02 clear when motor released, set when start possible.
// - Status bit 03 set while tripped and awaiting reset.
// - Status bits 04 and 05 are unused.
// - Status bit 06 set while trip-locked; reset ignored until power cycle.
// - Bit 07 any warning; bit 13 voltage, 14 current, 15 thermal.
// - Status bit 08 set when speed equals reference.
// - Status bit 09 clear when local stop or local control selected.
// - Status bit 10 set while output frequency strictly inside limits.
// - Status bit 11 set on start signal or positive (signed) output frequency.
// - Speed reference is signed 16-bit, 16384 equals full span.
// - Output frequency reported signed 16-bit, 4000 Hex equals full span.
// - Command bits 01..00 select one of four presets.
// - Command bit 02 zero applies DC braking and stop.
// - Command bit 03 zero coasts the motor immediately.
// - Command bit 04 zero performs quick stop ramp.
// - Command bit 05 zero freezes frequency; only coast or brake stop.
// - Command bit 06 zero ramps to stop; one allows start.
// - Trip reset only on rising edge of command bit 07.
// - Command word ignored when its bit 10 is zero.
// - Relays follow bits 11/12 when enabled; drop on bus timeout.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dcsw_top
  import dcsw_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [11:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        DRIVE_FAULT,
  input  wire logic        DRIVE_LOCK_FAULT,
  input  wire logic        LOCAL_MODE,
  input  wire logic        TERM_COAST,
  input  wire logic        VOLT_WARN,
  input  wire logic        CURR_WARN,
  input  wire logic        THERM_WARN,
  input  wire logic        START_INPUT,
  input  wire logic        MOTOR_RELEASED,
  input  wire logic [15:0] OUT_FREQ,
  input  wire logic [15:0] MOTOR_SPEED,
  input  wire logic [15:0] ACTIVE_REF,
  output logic      [1:0]  PRESET_SEL,
  output logic             DC_BRAKE,
  output logic             COAST,
  output logic             QUICK_STOP,
  output logic             FREEZE,
  output logic             RUN_ENABLE,
  output logic             TRIP_RESET,
  output logic      [15:0] SPEED_REF,
  output logic             RELAY1,
  output logic             RELAY2
);

  typedef struct packed {
    logic        wr_pend;
    logic        rd_pend;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [15:0] cmd;
    logic [15:0] speed_ref;
    logic [1:0]  config_bits;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    logic [31:0] tmo_ms;
    logic [31:0] tmo_cyc;
    logic [31:0] tmo_ms_cnt;
    logic        timed_out;
    logic        reset_prev;
    logic        trip_reset;
    logic        frozen;
    logic        stop_ramp;
    logic [15:0] status;
    logic        relay1;
    logic        relay2;
  } dcsw_state_type;

  dcsw_state_type st_r;
  dcsw_state_type st_nxt;

  logic        hit;
  logic        trip_active;
  logic        ready;
  logic        in_range;
  logic        running;
  logic [15:0] wd;
  logic [15:0] applied;
  logic        accept_cmd;

  always_comb begin
    st_nxt = st_r;
    hit = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    wd = HWDATA[15:0];
    accept_cmd = 1'b0;
    applied = st_r.cmd;
    // Address phase capture
    st_nxt.wr_pend = hit && HWRITE;
    st_nxt.rd_pend = hit && !HWRITE;
    if (hit) begin
      st_nxt.addr = HADDR;
    end
    // Data phase write
    if (st_r.wr_pend) begin
      case (st_r.addr)
        DCSW_ADDR_COMMAND: begin
          // Word without valid bit is discarded
          accept_cmd = wd[CMD_VALID];
          if (accept_cmd) begin
            st_nxt.cmd = wd;
            applied = wd;
          end
        end
        DCSW_ADDR_SPEEDREF: st_nxt.speed_ref = wd;
        DCSW_ADDR_CONFIG:   st_nxt.config_bits = HWDATA[1:0];
        DCSW_ADDR_LOLIM:    st_nxt.lo_lim = wd;
        DCSW_ADDR_HILIM:    st_nxt.hi_lim = wd;
        DCSW_ADDR_TMO:      st_nxt.tmo_ms = HWDATA;
        default: begin
        end
      endcase
    end
    // Bus timeout watchdog; any accepted command rearms it
    if (accept_cmd) begin
      st_nxt.tmo_cyc = 32'h0000_0000;
      st_nxt.tmo_ms_cnt = 32'h0000_0000;
      st_nxt.timed_out = 1'b0;
    end else if (st_r.tmo_ms != 32'h0000_0000 && !st_r.timed_out) begin
      if (st_r.tmo_cyc == 32'(TMO_UNIT_CYC - 1)) begin
        st_nxt.tmo_cyc = 32'h0000_0000;
        st_nxt.tmo_ms_cnt = st_r.tmo_ms_cnt + 32'h0000_0001;
        if (st_r.tmo_ms_cnt + 32'h0000_0001 >= st_r.tmo_ms) begin
          st_nxt.timed_out = 1'b1;
        end
      end else begin
        st_nxt.tmo_cyc = st_r.tmo_cyc + 32'h0000_0001;
      end
    end
    // Trip reset pulse on rising edge of command bit 07
    st_nxt.reset_prev = applied[CMD_RESET];
    st_nxt.trip_reset = applied[CMD_RESET] && !st_r.reset_prev
                        && !DRIVE_LOCK_FAULT;
    // Freeze: start bit cannot stop; only coast or brake stop
    st_nxt.frozen = !applied[CMD_FREEZE];
    st_nxt.stop_ramp = !applied[CMD_START] && applied[CMD_FREEZE];
    st_nxt.relay1 = applied[CMD_RELAY1] && st_r.config_bits[CFG_RELAY1_EN]
                    && !st_nxt.timed_out;
    st_nxt.relay2 = applied[CMD_RELAY2] && st_r.config_bits[CFG_RELAY2_EN]
                    && !st_nxt.timed_out;
    // Status assembly
    trip_active = DRIVE_FAULT || DRIVE_LOCK_FAULT;
    ready = !trip_active;
    in_range = ($signed(OUT_FREQ) > $signed(st_r.lo_lim))
               && ($signed(OUT_FREQ) < $signed(st_r.hi_lim));
    running = START_INPUT || ($signed(OUT_FREQ) > $signed(16'h0000));
    st_nxt.status = 16'h0000;
    st_nxt.status[ST_CTRL_READY] = ready;
    st_nxt.status[ST_DRIVE_READY] = ready && (TERM_COAST || !st_r.cmd[CMD_COAST]);
    st_nxt.status[ST_STANDBY] = !MOTOR_RELEASED && ready;
    st_nxt.status[ST_TRIP] = DRIVE_FAULT;
    st_nxt.status[ST_TRIP_LOCK] = DRIVE_LOCK_FAULT;
    st_nxt.status[ST_WARNING] = VOLT_WARN || CURR_WARN || THERM_WARN;
    st_nxt.status[ST_VOLT_WARN] = VOLT_WARN;
    st_nxt.status[ST_CURR_WARN] = CURR_WARN;
    st_nxt.status[ST_THERM_WARN] = THERM_WARN;
    st_nxt.status[ST_ON_REF] = (MOTOR_SPEED == ACTIVE_REF);
    st_nxt.status[ST_SERIAL_OK] = !LOCAL_MODE;
    st_nxt.status[ST_IN_RANGE] = in_range;
    st_nxt.status[ST_RUNNING] = running;
    // Read data for the following data phase
    st_nxt.rdata = 32'h0000_0000;
    if (hit && !HWRITE) begin
      case (HADDR)
        DCSW_ADDR_STATUS:   st_nxt.rdata = {16'h0000, st_r.status};
        DCSW_ADDR_SPEEDREF: st_nxt.rdata = {16'h0000, st_r.speed_ref};
        DCSW_ADDR_OUTFREQ:  st_nxt.rdata = {16'h0000, OUT_FREQ};
        DCSW_ADDR_CONFIG:   st_nxt.rdata = {30'h0000_0000, st_r.config_bits};
        DCSW_ADDR_LOLIM:    st_nxt.rdata = {16'h0000, st_r.lo_lim};
        DCSW_ADDR_HILIM:    st_nxt.rdata = {16'h0000, st_r.hi_lim};
        DCSW_ADDR_TMO:      st_nxt.rdata = st_r.tmo_ms;
        DCSW_ADDR_DRVOUT:   st_nxt.rdata = {30'h0000_0000, st_r.relay2, st_r.timed_out};
        default:            st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_r <= '0;
      st_r.cmd <= CMD_RST;
      st_r.speed_ref <= SPEEDREF_RST;
      st_r.config_bits <= CONFIG_RST;
      st_r.lo_lim <= LOLIM_RST;
      st_r.hi_lim <= HILIM_RST;
      st_r.tmo_ms <= TMO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    HRDATA = st_r.rdata;
    HREADYOUT = 1'b1;
    HRESP = 1'b0;
    PRESET_SEL = st_r.cmd[CMD_PRESET_HI:CMD_PRESET_LO];
    DC_BRAKE = !st_r.cmd[CMD_DC_BRAKE];
    COAST = !st_r.cmd[CMD_COAST];
    QUICK_STOP = !st_r.cmd[CMD_QSTOP];
    FREEZE = st_r.frozen;
    RUN_ENABLE = !st_r.stop_ramp && st_r.cmd[CMD_COAST];
    TRIP_RESET = st_r.trip_reset;
    SPEED_REF = st_r.speed_ref;
    RELAY1 = st_r.relay1;
    RELAY2 = st_r.relay2;
  end

endmodule
`default_nettype wire

// ---- dcsw_monitor.sv ----
// Assertion checker for the drive word block
`timescale 1ns/10ps
`default_nettype none
module dcsw_monitor
  import dcsw_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        DRIVE_LOCK_FAULT,
  input wire logic [1:0]  PRESET_SEL,
  input wire logic        DC_BRAKE,
  input wire logic        COAST,
  input wire logic        QUICK_STOP,
  input wire logic        FREEZE,
  input wire logic        TRIP_RESET,
  input wire logic [15:0] SPEED_REF
);
  logic acc, wc_r, wr_r, rs_r;
  assign acc = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  // Data-phase flags of writes to command and reference, reads of status
  always_ff @(posedge REF_CLK) begin
    wc_r <= !SYS_RST && acc && HWRITE && HADDR == DCSW_ADDR_COMMAND;
    wr_r <= !SYS_RST && acc && HWRITE && HADDR == DCSW_ADDR_SPEEDREF;
    rs_r <= !SYS_RST && acc && !HWRITE && HADDR == DCSW_ADDR_STATUS;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence cmd_ok; wc_r && HWDATA[CMD_VALID]; endsequence
  sequence cmd_no; wc_r && !HWDATA[CMD_VALID]; endsequence
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus wait or error response");
  preset_sel_a: assert property (cmd_ok |=> PRESET_SEL == $past(HWDATA[1:0]))
    else $error("preset select wrong");
  stop_bits_a: assert property (cmd_ok |=> {FREEZE, QUICK_STOP, COAST, DC_BRAKE} == ~$past(HWDATA[5:2]))
    else $error("stop outputs wrong");
  ignore_cmd_a: assert property (cmd_no |=> $stable({PRESET_SEL, DC_BRAKE, COAST, QUICK_STOP, FREEZE}))
    else $error("invalid command applied");
  trip_pulse_a: assert property (TRIP_RESET |-> $past(wc_r && HWDATA[CMD_VALID] && HWDATA[CMD_RESET]) ##1 !TRIP_RESET)
    else $error("trip reset pulse wrong");
  lock_block_a: assert property (DRIVE_LOCK_FAULT && $past(DRIVE_LOCK_FAULT) && $past(DRIVE_LOCK_FAULT, 2) |-> !TRIP_RESET)
    else $error("reset during trip lock");
  speed_ref_a: assert property (wr_r |=> SPEED_REF == $past(HWDATA[15:0]))
    else $error("speed reference wrong");
  unused_zero_a: assert property (rs_r |-> HRDATA[31:16] == 16'h0000 && HRDATA[5:4] == 2'h0 && !HRDATA[12])
    else $error("unused status bits set");
  warn_sum_a: assert property (rs_r |-> HRDATA[7] == |HRDATA[15:13])
    else $error("warning summary wrong");
  ready_a: assert property (rs_r |-> HRDATA[0] == !(HRDATA[3] || HRDATA[6]) && (HRDATA[2] <= HRDATA[0]))
    else $error("ready bit wrong");
endmodule
bind dcsw_top dcsw_monitor dcsw_monitor_i (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .DRIVE_LOCK_FAULT(DRIVE_LOCK_FAULT), .PRESET_SEL(PRESET_SEL),
  .DC_BRAKE(DC_BRAKE), .COAST(COAST), .QUICK_STOP(QUICK_STOP), .FREEZE(FREEZE),
  .TRIP_RESET(TRIP_RESET), .SPEED_REF(SPEED_REF)
);
`default_nettype wire

// ---- dcsw_bus_master.sv ----
// Bus master model issuing single word transfers
`timescale 1ns/10ps
`default_nettype none
module dcsw_bus_master
  import dcsw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int tmo = 0;
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // Address phase held until ready, then data phase; released data is inverted
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 64);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 128);
    q = hrdata;
    hwdata <= ~d;
    if (hready !== 1'h1) tmo++;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the drive word block
`timescale 1ns/10ps
`default_nettype none
module tb
  import dcsw_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [8:0]  pin = 9'h000;
  logic [15:0] frq = 16'h0000, spd = 16'h0000, sref;
  logic        hsel, hwr, hrdy, hresp, trp, rl1, rl2, dcb, cst, qst, frz, run;
  logic [11:0] haddr;
  logic [1:0]  htr, psel;
  logic [2:0]  hsz;
  logic [31:0] hwd, hrd, q;
  int          miscompares = 0, compares = 0;
  always #20 clk = ~clk;
  dcsw_bus_master dcsw_bus_master_i (.clk(clk), .hready(hrdy), .hrdata(hrd), .hsel(hsel),
    .haddr(haddr), .htrans(htr), .hwrite(hwr), .hsize(hsz), .hwdata(hwd));
  dcsw_top dcsw_top_i (.REF_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htr), .HWRITE(hwr), .HSIZE(hsz), .HWDATA(hwd), .HREADY(hrdy), .HRDATA(hrd),
    .HREADYOUT(hrdy), .HRESP(hresp), .DRIVE_FAULT(pin[8]), .DRIVE_LOCK_FAULT(pin[7]),
    .LOCAL_MODE(pin[6]), .TERM_COAST(pin[5]), .VOLT_WARN(pin[4]), .CURR_WARN(pin[3]),
    .THERM_WARN(pin[2]), .START_INPUT(pin[1]), .MOTOR_RELEASED(pin[0]), .OUT_FREQ(frq),
    .MOTOR_SPEED(spd), .ACTIVE_REF(16'h0000), .PRESET_SEL(psel), .DC_BRAKE(dcb), .COAST(cst),
    .QUICK_STOP(qst), .FREEZE(frz), .RUN_ENABLE(run), .TRIP_RESET(trp), .SPEED_REF(sref),
    .RELAY1(rl1), .RELAY2(rl2));
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    dcsw_bus_master_i.xfer(w, a, d, q);
    if (dcsw_bus_master_i.tmo != 0) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // Status expected with command coast bit clear and reset frequency limits
  function automatic logic [15:0] exp_st(input logic [8:0] p, input logic [15:0] f);
    logic rdy;
    rdy = !p[8] && !p[7];
    exp_st = {p[2], p[3], p[4], 1'h0, p[1] || $signed(f) > 0,
              $signed(f) > $signed(LOLIM_RST) && $signed(f) < $signed(HILIM_RST), !p[6],
              spd == 16'h0000, |p[4:2], p[7], 2'h0, p[8], rdy && !p[0], rdy, rdy};
  endfunction
  task automatic t_status();
    logic [8:0]  v [6] = '{9'h000, 9'h100, 9'h080, 9'h05C, 9'h023, 9'h001};
    logic [15:0] f [6] = '{16'h0000, 16'h2000, 16'h4000, 16'hE000, 16'h0001, 16'h3FFF};
    for (int i = 0; i < 6; i++) begin
      pin <= v[i];
      frq <= f[i];
      spd <= {15'h0000, i[0]};
      repeat (3) @(posedge clk);
      rw(1'h0, DCSW_ADDR_STATUS, 32'h0);
      chk("status", {16'h0000, exp_st(v[i], f[i])}, q);
      rw(1'h0, DCSW_ADDR_OUTFREQ, 32'h0);
      chk("out freq", {16'h0000, f[i]}, q);
    end
    pin <= 9'h000;
    $display("status test done");
  endtask
  task automatic t_cmd();
    logic [15:0] cw [11] = '{16'h047F, 16'h047F, 16'h007B, 16'h041F, 16'h0417, 16'h0480,
                             16'h0400, 16'h0401, 16'h0402, 16'h0400, 16'h0480};
    logic [7:0]  ex [11] = '{8'hC2, 8'hC2, 8'hC2, 8'hC6, 8'hD4, 8'h3D,
                             8'h3C, 8'h7C, 8'hBC, 8'h3C, 8'h3C};
    for (int i = 0; i < 11; i++) begin
      pin[7] <= i > 8;
      rw(1'h1, DCSW_ADDR_COMMAND, {16'h0000, cw[i]});
      @(negedge clk);
      chk("controls", {24'h0, ex[i]}, {24'h0, psel, dcb, cst, qst, frz, run, trp});
    end
    pin <= 9'h000;
    $display("command test done");
  endtask
  task automatic t_map();
    rw(1'h1, DCSW_ADDR_SPEEDREF, 32'h0000E000);
    @(negedge clk);
    chk("speed ref", 32'h0000E000, {16'h0000, sref});
    rw(1'h1, 12'h100, 32'hFFFFFFFF);
    rw(1'h0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, q);
    rw(1'h0, DCSW_ADDR_COMMAND, 32'h0);
    chk("command read", 32'h0, q);
    $display("map test done");
  endtask
  task automatic t_relay();
    int n;
    rw(1'h1, DCSW_ADDR_CONFIG, 32'h3);
    rw(1'h1, DCSW_ADDR_TMO, 32'h1);
    rw(1'h1, DCSW_ADDR_COMMAND, 32'h1C00);
    @(negedge clk);
    chk("relays on", 32'h3, {30'h0, rl1, rl2});
    n = 0;
    while (rl1 === 1'h1 && n < 30000) begin @(negedge clk); n++; end
    chk("relay timeout", 32'h1, {31'h0, n > 24990 && n < 25010});
    chk("relays off", 32'h0, {30'h0, rl1, rl2});
    rw(1'h1, DCSW_ADDR_CONFIG, 32'h0);
    rw(1'h1, DCSW_ADDR_COMMAND, 32'h1C00);
    @(negedge clk);
    chk("relays disabled", 32'h0, {30'h0, rl1, rl2});
    $display("relay test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_status();
    t_cmd();
    t_map();
    t_relay();
    end_of_test();
  end
endmodule
`default_nettype wire
